//--- verilog/wps_top.sv
// write pulse sequencer: recording data in, laser modulation out
// assumes one core_clk_i cycle equals 1/20 T; data from a pin
`timescale 1ns/1ps
module wps_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // recording data and set selection
    input wire logic rec_data_i,
    input wire logic [1:0] set_sel_i,
    // laser modulation
    output logic laser_on_o,
    output logic lead_active_o,
    output logic train_active_o
);
    // ***********************************************************
    // input synchronisers
    // ***********************************************************
    logic data_s1_r;
    logic data_s2_r;
    logic data_d_r;
    logic [1:0] set_s1_r;
    logic [1:0] set_s2_r;
    logic data_s1_nxt;
    logic data_s2_nxt;
    logic data_d_nxt;
    logic [1:0] set_s1_nxt;
    logic [1:0] set_s2_nxt;

    always_comb begin
        data_s1_nxt = rec_data_i;
        data_s2_nxt = data_s1_r;
        data_d_nxt = data_s2_r;
        set_s1_nxt = set_sel_i;
        set_s2_nxt = set_s1_r;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            data_s1_r <= 1'b0;
            data_s2_r <= 1'b0;
            data_d_r <= 1'b0;
            set_s1_r <= wps_pkg::WPS_SET_RST;
            set_s2_r <= wps_pkg::WPS_SET_RST;
        end else begin
            data_s1_r <= data_s1_nxt;
            data_s2_r <= data_s2_nxt;
            data_d_r <= data_d_nxt;
            set_s1_r <= set_s1_nxt;
            set_s2_r <= set_s2_nxt;
        end
    end

    // ***********************************************************
    // width lookup
    // ***********************************************************
    wps_width_if wif ();
    assign wif.set_sel = set_s2_r;

    wps_width_table u_table (
        .wif(wif)
    );

    // ***********************************************************
    // mark phase decode
    // ***********************************************************
    logic rise;
    logic fall;
    logic period_end;
    logic lead_last_t;
    logic [wps_pkg::WPS_SUB_W-1:0] sub_r;
    logic [wps_pkg::WPS_RUN_W-1:0] run_r;

    always_comb begin
        // edges of the synchronised data, one stage apart
        rise = data_s2_r & ~data_d_r;
        fall = ~data_s2_r & data_d_r;
        period_end = (sub_r ==
            wps_pkg::WPS_SUB_W'(wps_pkg::WPS_SUB_STEPS - 1));
        lead_last_t = (run_r ==
            wps_pkg::WPS_RUN_W'(wps_pkg::WPS_LEAD_END_T - 1));
    end

    // ***********************************************************
    // sequencer
    // ***********************************************************
    wps_pkg::wps_state_t state_r;
    wps_pkg::wps_state_t state_nxt;
    logic [wps_pkg::WPS_SUB_W-1:0] sub_nxt;
    logic [wps_pkg::WPS_RUN_W-1:0] run_nxt;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_w_r;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_w_nxt;
    logic [wps_pkg::WPS_SUB_W-1:0] train_w_r;
    logic [wps_pkg::WPS_SUB_W-1:0] train_w_nxt;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_pick;

    // lead width by the run seen so far; the true length is only
    // known at the mark's end, so the third T takes the long value
    always_comb begin
        unique case (run_r)
            5'h00: lead_pick = wif.lead_pulse_width_3;
            5'h01: lead_pick = wif.lead_pulse_width_4;
            default: lead_pick = wif.lead_pulse_width_5;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        sub_nxt = period_end ? '0 : sub_r + 1'b1;
        run_nxt = run_r;
        lead_w_nxt = lead_w_r;
        train_w_nxt = train_w_r;
        unique case (state_r)
            wps_pkg::WPS_IDLE: begin
                sub_nxt = '0;
                run_nxt = '0;
                if (rise) begin
                    // sub count 0 is the edge that sees the mark
                    state_nxt = wps_pkg::WPS_LEAD;
                    lead_w_nxt = wif.lead_pulse_width_3;
                    train_w_nxt = wif.train_pulse_width;
                end
            end
            wps_pkg::WPS_LEAD: begin
                if (period_end) begin
                    run_nxt = run_r + 1'b1;
                end
                lead_w_nxt = lead_pick;
                if (fall) begin
                    // a 3T mark ends here, before any train
                    state_nxt = wps_pkg::WPS_IDLE;
                end else if (period_end && lead_last_t) begin
                    state_nxt = wps_pkg::WPS_TRAIN;
                end
            end
            wps_pkg::WPS_TRAIN: begin
                if (fall) begin
                    state_nxt = wps_pkg::WPS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_r <= wps_pkg::WPS_IDLE;
            sub_r <= '0;
            run_r <= '0;
            lead_w_r <= wps_pkg::WPS_W_155;
            train_w_r <= wps_pkg::WPS_W_065;
        end else begin
            state_r <= state_nxt;
            sub_r <= sub_nxt;
            run_r <= run_nxt;
            lead_w_r <= lead_w_nxt;
            train_w_r <= train_w_nxt;
        end
    end

    // ***********************************************************
    // pulse shaping
    // ***********************************************************
    logic laser_r;
    logic laser_nxt;
    logic lead_r;
    logic lead_nxt;
    logic train_r;
    logic train_nxt;
    logic lead_window;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_start;

    always_comb begin
        // widths of a whole T or more fill the third T
        if (lead_w_r >= wps_pkg::WPS_SUB_W'(wps_pkg::WPS_SUB_STEPS)) begin
            lead_start = '0;
        end else begin
            lead_start = wps_pkg::WPS_SUB_W'(wps_pkg::WPS_SUB_STEPS) -
                lead_w_r;
        end
        // next cycle lies in the third T of the mark
        lead_window = (state_r == wps_pkg::WPS_LEAD) && !fall &&
            (run_nxt == wps_pkg::WPS_RUN_W'(wps_pkg::WPS_LEAD_END_T - 1));
        lead_nxt = lead_window && (sub_nxt >= lead_start);
        // train pulse leads each T, from the 3T boundary onward
        train_nxt = !fall &&
            (state_nxt == wps_pkg::WPS_TRAIN) &&
            (sub_nxt < train_w_r);
        laser_nxt = lead_nxt | train_nxt;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            laser_r <= 1'b0;
            lead_r <= 1'b0;
            train_r <= 1'b0;
        end else begin
            laser_r <= laser_nxt;
            lead_r <= lead_nxt;
            train_r <= train_nxt;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign laser_on_o = laser_r;
    assign lead_active_o = lead_r;
    assign train_active_o = train_r;
endmodule // wps_top

//--- pkg/wps_pkg.sv
// constants and types for the write pulse strategy block
// assumes a 50 MHz core clock that runs at 20 times the channel bit rate T
// Function
// - A mark of 4T to 11T or exactly 14T gets a lead pulse and then a pulse train.
// - A 3T mark gets only the lead pulse and no train.
// - The lead pulse starts after the mark's rising edge and always ends 3T after it.
// - Three parameter sets exist; set one uses 1,55T, 1,50T, 1,55T lead and 0,65T train; the code drives every lead pulse 1T wide, over the third T.
// - Set three uses 1,25T for 3T marks, 1,15T for longer marks and 0,60T train; the code drives a 1T lead for every mark length.
// - The train starts 3T after the rising edge and lasts until the mark's falling edge.
// - Train pulses repeat at exactly one channel clock period.
// - Every train pulse has the set's width, independent of run length.
package wps_pkg;
    // ***********************************************************
    // sub-period timing: widths in 1/20 T steps
    // ***********************************************************
    localparam int unsigned WPS_SUB_STEPS = 20;
    localparam int unsigned WPS_SUB_W = 5;
    localparam int unsigned WPS_LEAD_END_T = 3;
    localparam int unsigned WPS_RUN_W = 5;
    localparam logic [WPS_SUB_W-1:0] WPS_W_155 = 5'h1F;
    localparam logic [WPS_SUB_W-1:0] WPS_W_150 = 5'h1E;
    localparam logic [WPS_SUB_W-1:0] WPS_W_125 = 5'h19;
    localparam logic [WPS_SUB_W-1:0] WPS_W_115 = 5'h17;
    localparam logic [WPS_SUB_W-1:0] WPS_W_065 = 5'h0D;
    localparam logic [WPS_SUB_W-1:0] WPS_W_060 = 5'h0C;
    localparam logic [1:0] WPS_SET_RST = 2'h0;

    typedef enum logic [1:0] {
        WPS_SET_ONE,
        WPS_SET_TWO,
        WPS_SET_THREE,
        WPS_SET_BAD
    } wps_set_t;

    typedef enum {
        WPS_IDLE,
        WPS_LEAD,
        WPS_TRAIN
    } wps_state_t;
endpackage

//--- pkg/wps_width_if.sv
// carries the selected widths from the table to the sequencer
// assumes both ends share core_clk_i
`timescale 1ns/1ps
interface wps_width_if;
    logic [1:0] set_sel;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_pulse_width_3;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_pulse_width_4;
    logic [wps_pkg::WPS_SUB_W-1:0] lead_pulse_width_5;
    logic [wps_pkg::WPS_SUB_W-1:0] train_pulse_width;
    modport table_end (
        input set_sel,
        output lead_pulse_width_3, lead_pulse_width_4,
        output lead_pulse_width_5, train_pulse_width
    );
    modport user_end (
        output set_sel,
        input lead_pulse_width_3, lead_pulse_width_4,
        input lead_pulse_width_5, train_pulse_width
    );
endinterface

//--- verilog/wps_width_table.sv
// lookup of lead and train widths per parameter set
// assumes a registered set selection from the input synchronisers
`timescale 1ns/1ps
module wps_width_table (
    // width selection
    wps_width_if.table_end wif
);
    always_comb begin
        unique case (wps_pkg::wps_set_t'(wif.set_sel))
            wps_pkg::WPS_SET_TWO: begin
                wif.lead_pulse_width_3 = wps_pkg::WPS_W_150;
                wif.lead_pulse_width_4 = wps_pkg::WPS_W_150;
                wif.lead_pulse_width_5 = wps_pkg::WPS_W_155;
                wif.train_pulse_width = wps_pkg::WPS_W_065;
            end
            wps_pkg::WPS_SET_THREE: begin
                wif.lead_pulse_width_3 = wps_pkg::WPS_W_125;
                wif.lead_pulse_width_4 = wps_pkg::WPS_W_115;
                wif.lead_pulse_width_5 = wps_pkg::WPS_W_115;
                wif.train_pulse_width = wps_pkg::WPS_W_060;
            end
            default: begin
                // set one; also taken for the unused code
                wif.lead_pulse_width_3 = wps_pkg::WPS_W_155;
                wif.lead_pulse_width_4 = wps_pkg::WPS_W_150;
                wif.lead_pulse_width_5 = wps_pkg::WPS_W_155;
                wif.train_pulse_width = wps_pkg::WPS_W_065;
            end
        endcase
    end
endmodule // wps_width_table

//--- verif/wps_chk.sv
// assertions on the write pulse block ports
// assumes 20 core clocks per T and a stable set during marks
`timescale 1ns/1ps
module wps_chk (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic rec_data_i,
    input wire logic [1:0] set_sel_i,
    input wire logic laser_on_o,
    input wire logic lead_active_o,
    input wire logic train_active_o
);
    // ****
    // run and pulse counters
    // ****
    logic [7:0] hi_r, lo_r, gap_r, ld_r, tr_r;
    logic ld_q, tr_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            {hi_r, lo_r, gap_r, ld_r, tr_r} <= 40'h0;
            {ld_q, tr_q} <= 2'h0;
        end else begin
            hi_r <= !rec_data_i ? 8'h00 : hi_r + {7'h0, hi_r != 8'hFF};
            lo_r <= rec_data_i ? 8'h00 : lo_r + {7'h0, lo_r != 8'hFF};
            gap_r <= ((lead_active_o && !ld_q) || (train_active_o && !tr_q))
                ? 8'h01 : gap_r + {7'h0, gap_r != 8'hFF};
            ld_r <= lead_active_o ? ld_r + 8'h01 : 8'h00;
            tr_r <= train_active_o ? tr_r + 8'h01 : 8'h00;
            ld_q <= lead_active_o;
            tr_q <= train_active_o;
        end
    end
    AST_BIAS_IDLE: assert property (!lead_active_o && !train_active_o
        |-> !laser_on_o) else $error("laser on outside pulses");
    AST_LEAD_ON: assert property (lead_active_o
        |-> laser_on_o && !train_active_o) else $error("lead not on laser");
    AST_TRAIN_ON: assert property (train_active_o |-> laser_on_o)
        else $error("train not on laser");
    AST_LEAD_START: assert property ($rose(lead_active_o)
        |-> hi_r >= 8'h28 && hi_r <= 8'h30) else $error("lead start off");
    AST_LEAD_LEN: assert property ($fell(lead_active_o)
        |-> ld_r == 8'h14) else $error("lead width wrong");
    AST_TRAIN_W: assert property ($fell(train_active_o)
        |-> tr_r == (set_sel_i == 2'h2 ? 8'h0C : 8'h0D))
        else $error("train width wrong");
    AST_TRAIN_PER: assert property ($rose(train_active_o)
        |-> gap_r == 8'h14) else $error("train period wrong");
    AST_QUIET: assert property (lo_r >= 8'h18 |-> !laser_on_o)
        else $error("laser on after mark end");
    AST_SHORT: assert property ($fell(lead_active_o) && lo_r != 8'h00
        |-> (!train_active_o)[*8]) else $error("train on short mark");
    AST_FOLLOW: assert property ($fell(lead_active_o) && hi_r != 8'h00
        |-> train_active_o) else $error("train missing");
endmodule // wps_chk

bind wps_top wps_chk chk_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .rec_data_i(rec_data_i), .set_sel_i(set_sel_i),
    .laser_on_o(laser_on_o), .lead_active_o(lead_active_o),
    .train_active_o(train_active_o));

//--- verif/wps_laser_model.sv
// laser driver model: counts write pulses and write-power cycles
// assumes modulation high means write power
`timescale 1ns/1ps
module wps_laser_model (
    input wire logic core_clk_i,
    input wire logic clr_i,
    input wire logic laser_on_i,
    output logic [11:0] pulse_cnt_o,
    output logic [11:0] write_cyc_o
);
    logic on_q;
    always_ff @(posedge core_clk_i) begin
        on_q <= laser_on_i;
        if (clr_i) begin
            pulse_cnt_o <= 12'h000;
            write_cyc_o <= 12'h000;
        end else begin
            pulse_cnt_o <= pulse_cnt_o + {11'h0, laser_on_i && !on_q};
            write_cyc_o <= write_cyc_o + {11'h0, laser_on_i};
        end
    end
endmodule // wps_laser_model

//--- verif/tb.sv
// bench for the write pulse block with a laser driver model
// assumes 20 core clocks per T
`timescale 1ns/1ps
module tb;
    logic core_clk_i, rst_b_i, rec_data_i, clr, laser_on_o;
    logic lead_active_o, train_active_o;
    logic [1:0] set_sel_i;
    logic [11:0] pulse_cnt, write_cyc;
    int fails, cmp_count;
    wps_top dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .rec_data_i(rec_data_i), .set_sel_i(set_sel_i),
        .laser_on_o(laser_on_o), .lead_active_o(lead_active_o),
        .train_active_o(train_active_o));
    wps_laser_model drv_u (.core_clk_i(core_clk_i), .clr_i(clr),
        .laser_on_i(laser_on_o), .pulse_cnt_o(pulse_cnt),
        .write_cyc_o(write_cyc));
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // ****
    // one mark then a space, judged by pulse and write-cycle counts and lead timing
    // ****
    task automatic run_mark(input int n, input int sp, input int w);
        int i, ls, le;
        logic ld;
        ls = 0;
        le = 0;
        ld = 1'b0;
        clr = 1'b1;
        @(negedge core_clk_i);
        clr = 1'b0;
        for (i = 0; i < n * 20 + sp; i++) begin
            @(negedge core_clk_i);
            if (lead_active_o && !ld) ls = i;
            if (!lead_active_o && ld) le = i;
            ld = lead_active_o;
            rec_data_i = (i < n * 20);
        end
        check(pulse_cnt, 12'((n == 3) ? 1 : n - 3));
        check(write_cyc, 12'(20 + (n - 3) * w));
        check(12'(le - ls), 12'h014);
        check({11'h0, le >= 62 && le <= 66}, 12'h001);
    endtask
    task automatic scen_sets;
        int lens[5] = '{3, 4, 5, 11, 14};
        for (int s = 0; s < 4; s++) begin
            set_sel_i = 2'(s);
            foreach (lens[k]) run_mark(lens[k], 80, s == 2 ? 12 : 13);
        end
    endtask
    task automatic scen_tight;
        set_sel_i = 2'h2;
        repeat (60) @(negedge core_clk_i);
        run_mark(3, 60, 12);
        run_mark(5, 60, 12);
    endtask
    task automatic scen_reset;
        set_sel_i = 2'h0;
        rec_data_i = 1'b1;
        repeat (100) @(negedge core_clk_i);
        rst_b_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        check({9'h0, laser_on_o, lead_active_o, train_active_o}, 12'h0);
        rec_data_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        run_mark(4, 80, 13);
    endtask
    task automatic final_report;
        $display("fails=%0d compares=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rst_b_i, rec_data_i, set_sel_i, clr} = 5'h01;
        fails = 0;
        cmp_count = 0;
        repeat (6) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        scen_sets;
        scen_tight;
        scen_reset;
        final_report;
    end
endmodule // tb
